// [gdsp_pkg.sv]
// Package: register map, field layout, defaults, power states and timing for the gyro DSP bank
package gdsp_pkg;

    // Register and command addresses
    localparam logic [7:0] ADDR_HIGHPASS_FILTER_CFG      = 8'h01;
    localparam logic [7:0] ADDR_LOWPASS_FILTER_CFG       = 8'h02;
    localparam logic [7:0] ADDR_CALIB_AND_DECIMATION_CFG = 8'h03;
    localparam logic [7:0] ADDR_POWER_AND_READY_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_ENTER_SLEEP_CMD          = 8'h05;
    localparam logic [7:0] ADDR_WAKE_CMD                 = 8'h06;
    localparam logic [7:0] ADDR_STANDBY_CMD              = 8'h07;
    localparam logic [7:0] ADDR_TEMP_READ_ACCESS         = 8'h08;
    localparam logic [7:0] ADDR_SOFT_RESET_CMD           = 8'h09;
    localparam logic [7:0] ADDR_RATE_READ_ACCESS         = 8'h0a;
    localparam logic [7:0] ADDR_ZERO_CAL_CMD             = 8'h0c;

    // Field positions
    localparam int HP_CORNER_LSB    = 4;
    localparam int HP_CORNER_MSB    = 6;
    localparam int HP_ON_BIT        = 1;
    localparam int LP_ORDER_LSB     = 4;
    localparam int LP_ORDER_MSB     = 5;
    localparam int LP_CORNER_LSB    = 0;
    localparam int LP_CORNER_MSB    = 3;
    localparam int ZERO_CAL_BIT     = 6;
    localparam int DECIM_LSB        = 0;
    localparam int DECIM_MSB        = 2;
    localparam int TEMP_READY_BIT   = 3;

    // Field defaults
    localparam logic [2:0] HP_CORNER_DEF = 3'h2;
    localparam logic       HP_ON_DEF     = 1'b0;
    localparam logic [1:0] LP_ORDER_DEF  = 2'h0;
    localparam logic [3:0] LP_CORNER_DEF = 4'h6;
    localparam logic       ZERO_CAL_DEF  = 1'b0;
    localparam logic [2:0] DECIM_DEF     = 3'h0;

    // Reserved bit images: read back as their defaults
    localparam logic [7:0] HP_RSVD_IMAGE = 8'h01;
    localparam logic [7:0] LP_RSVD_IMAGE = 8'h00;
    localparam logic [7:0] CD_RSVD_IMAGE = 8'h00;

    // Codes that are not permitted, and the highest permitted low-pass corner code
    localparam logic [2:0] HP_CORNER_BAD = 3'h7;
    localparam logic [1:0] LP_ORDER_BAD  = 2'h3;
    localparam logic [3:0] LP_CORNER_MAX = 4'hc;

    // Power state, coded as it appears in status bits 2..0
    typedef enum logic [2:0] {
        GDSP_PWR_SLEEP    = 3'b000,
        GDSP_PWR_AWAKE    = 3'b001,
        GDSP_PWR_STANDBY  = 3'b010,
        GDSP_PWR_POWER_ON = 3'b100
    } gdsp_pwr_t;

    // Wait before a wake command is honoured
    localparam int CLK_FREQ_HZ       = 25_000_000;
    localparam int WAKE_WAIT_TIME_US = 10;
    localparam int WAKE_WAIT_CYC     = (WAKE_WAIT_TIME_US * (CLK_FREQ_HZ / 1_000_000));
    localparam logic [8:0] WAKE_WAIT_CNT = 9'(WAKE_WAIT_CYC);

    // Host access to the bank
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gdsp_access_t;

    // Filter settings towards the DSP
    typedef struct packed {
        logic [2:0] hp_corner_sel;
        logic       hp_on;
        logic [1:0] lp_order_sel;
        logic [3:0] lp_corner_sel;
        logic [2:0] output_decimation_sel;
        logic       zero_cal_allow;
    } gdsp_cfg_t;

endpackage : gdsp_pkg

// [gdsp_regs.sv]
// Gyro DSP user command registers, power commands and read accesses
// Contract
// - Three-bit high-pass corner field; code 111 is refused.
// - High-pass filter is applied only while its enable bit is one.
// - Two-bit low-pass order field; code 11 is refused.
// - Four-bit low-pass corner, codes 0000 to 1100 valid; others refused.
// - Three-bit field picks rate down-sampling from undivided to divide by 128.
// - Zero-rate calibration command acts only while its enable bit is set.
// - Status bit 3 shows temperature data ready.
// - Status bits 2..0 show power state: 100, 010, 000 or 001 only.
// - Sleep-in command at 0x05 enters sleep; only register access then.
// - In sleep or standby, rate and temperature data status reads zero.
// - Sleep-out at 0x06 leaves sleep or standby and resets the DSP.
// - Standby command at 0x07 disables the detection circuit.
// - Only sleep-out leaves standby; here the sleep-in command at 0x05 also leaves it.
// - Standby command while asleep is ignored.
// - Address 0x08 returns temperature data; writes are ignored.
// - Address 0x0a returns angular-rate data; no write phase.
// - Software reset at 0x09 restores all user command registers to defaults.
// - Power and reset commands carry no data bytes.
`timescale 1ns/10ps
module gdsp_regs
(
    // Clock and reset
    input  wire logic                 CLK,
    input  wire logic                 RST,
    // Host access
    input  wire gdsp_pkg::gdsp_access_t ACC,
    output logic                      RD_VALID,
    output logic [7:0]                RD_DATA,
    // Sensor data from the signal path
    input  wire logic                 TEMP_READY,
    input  wire logic [7:0]           TEMP_DATA,
    input  wire logic [7:0]           RATE_DATA,
    // Controls towards the signal path
    output gdsp_pkg::gdsp_cfg_t       CFG,
    output logic                      DETECT_EN,
    output logic                      DATA_PATH_EN,
    output logic                      DSP_RESET,
    output logic                      ZERO_CAL_START,
    output logic                      TEMP_READ_STB,
    output logic                      RATE_READ_STB
);
    import gdsp_pkg::*;

    gdsp_pwr_t  pwr_r;
    gdsp_pwr_t  pwr_nxt;
    logic [8:0] wait_cnt_r;
    logic       wait_done;
    logic       active;
    logic       wr;
    logic       rd;
    logic       soft_rst;
    logic       wake_ok;
    logic [7:0] rd_nxt;

    assign wr        = ACC.valid && ACC.write;
    assign rd        = ACC.valid && !ACC.write;
    // commands act on the address alone
    assign soft_rst  = ACC.valid && (ACC.addr == ADDR_SOFT_RESET_CMD);
    assign wait_done = (wait_cnt_r >= WAKE_WAIT_CNT);
    assign active    = (pwr_r == GDSP_PWR_AWAKE) || (pwr_r == GDSP_PWR_POWER_ON);
    // early wake is dropped, not queued
    assign wake_ok   = ACC.valid && (ACC.addr == ADDR_WAKE_CMD) && !active && wait_done;

    // corner write, invalid code keeps old value
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            CFG.hp_corner_sel <= HP_CORNER_DEF;
        end
        else if (soft_rst)
        begin
            CFG.hp_corner_sel <= HP_CORNER_DEF;
        end
        else if (wr && ACC.addr == ADDR_HIGHPASS_FILTER_CFG &&
                 ACC.wdata[HP_CORNER_MSB:HP_CORNER_LSB] != HP_CORNER_BAD)
        begin
            CFG.hp_corner_sel <= ACC.wdata[HP_CORNER_MSB:HP_CORNER_LSB];
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            CFG.hp_on <= HP_ON_DEF;
        end
        else if (soft_rst)
        begin
            CFG.hp_on <= HP_ON_DEF;
        end
        else if (wr && ACC.addr == ADDR_HIGHPASS_FILTER_CFG)
        begin
            CFG.hp_on <= ACC.wdata[HP_ON_BIT];
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            CFG.lp_order_sel <= LP_ORDER_DEF;
        end
        else if (soft_rst)
        begin
            CFG.lp_order_sel <= LP_ORDER_DEF;
        end
        else if (wr && ACC.addr == ADDR_LOWPASS_FILTER_CFG &&
                 ACC.wdata[LP_ORDER_MSB:LP_ORDER_LSB] != LP_ORDER_BAD)
        begin
            CFG.lp_order_sel <= ACC.wdata[LP_ORDER_MSB:LP_ORDER_LSB];
        end
    end

    // corner field, codes above 1100 refused
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            CFG.lp_corner_sel <= LP_CORNER_DEF;
        end
        else if (soft_rst)
        begin
            CFG.lp_corner_sel <= LP_CORNER_DEF;
        end
        else if (wr && ACC.addr == ADDR_LOWPASS_FILTER_CFG &&
                 ACC.wdata[LP_CORNER_MSB:LP_CORNER_LSB] <= LP_CORNER_MAX)
        begin
            CFG.lp_corner_sel <= ACC.wdata[LP_CORNER_MSB:LP_CORNER_LSB];
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            CFG.output_decimation_sel <= DECIM_DEF;
            CFG.zero_cal_allow        <= ZERO_CAL_DEF;
        end
        else if (soft_rst)
        begin
            CFG.output_decimation_sel <= DECIM_DEF;
            CFG.zero_cal_allow        <= ZERO_CAL_DEF;
        end
        else if (wr && ACC.addr == ADDR_CALIB_AND_DECIMATION_CFG)
        begin
            CFG.output_decimation_sel <= ACC.wdata[DECIM_MSB:DECIM_LSB];
            CFG.zero_cal_allow        <= ACC.wdata[ZERO_CAL_BIT];
        end
    end

    // Power state transitions
    always_comb
    begin
        pwr_nxt = pwr_r;
        if (ACC.valid)
        begin
            case (ACC.addr)
                ADDR_ENTER_SLEEP_CMD:
                    pwr_nxt = GDSP_PWR_SLEEP;
                ADDR_STANDBY_CMD:
                    if (pwr_r != GDSP_PWR_SLEEP)
                        pwr_nxt = GDSP_PWR_STANDBY;
                // only wake leaves sleep; wake or the sleep command leaves standby
                ADDR_WAKE_CMD:
                    if (wake_ok)
                        pwr_nxt = GDSP_PWR_AWAKE;
                default:
                    pwr_nxt = pwr_r;
            endcase
        end
    end

    // state register holds only legal codes
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            pwr_r <= GDSP_PWR_POWER_ON;
        end
        else
        begin
            pwr_r <= pwr_nxt;
        end
    end

    // time since the last sleep command or the last standby command taken outside sleep
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            wait_cnt_r <= '0;
        end
        else if (ACC.valid && (ACC.addr == ADDR_ENTER_SLEEP_CMD ||
                 (ACC.addr == ADDR_STANDBY_CMD && pwr_r != GDSP_PWR_SLEEP)))
        begin
            // Command edge counts as the first waited cycle
            wait_cnt_r <= 9'h001;
        end
        // Saturates so a long sleep never wraps into a refusal
        else if (!wait_done)
        begin
            wait_cnt_r <= wait_cnt_r + 9'h001;
        end
    end

    // Command pulses and power-derived levels
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            DSP_RESET      <= 1'b0;
            ZERO_CAL_START <= 1'b0;
            TEMP_READ_STB  <= 1'b0;
            RATE_READ_STB  <= 1'b0;
            DETECT_EN      <= 1'b1;
            DATA_PATH_EN   <= 1'b1;
        end
        else
        begin
            // DSP reset on a taken wake
            DSP_RESET      <= wake_ok;
            ZERO_CAL_START <= ACC.valid && ACC.addr == ADDR_ZERO_CAL_CMD &&
                              CFG.zero_cal_allow;
            // Strobes fire in any power state
            TEMP_READ_STB  <= rd && ACC.addr == ADDR_TEMP_READ_ACCESS;
            RATE_READ_STB  <= rd && ACC.addr == ADDR_RATE_READ_ACCESS;
            DETECT_EN      <= (pwr_nxt != GDSP_PWR_STANDBY);
            DATA_PATH_EN   <= (pwr_nxt == GDSP_PWR_AWAKE) ||
                              (pwr_nxt == GDSP_PWR_POWER_ON);
        end
    end

    // Read mux; reserved bits come from fixed images
    always_comb
    begin
        rd_nxt = 8'h00;
        case (ACC.addr)
            ADDR_HIGHPASS_FILTER_CFG:
            begin
                rd_nxt = HP_RSVD_IMAGE;
                rd_nxt[HP_CORNER_MSB:HP_CORNER_LSB] = CFG.hp_corner_sel;
                rd_nxt[HP_ON_BIT] = CFG.hp_on;
            end
            ADDR_LOWPASS_FILTER_CFG:
            begin
                rd_nxt = LP_RSVD_IMAGE;
                rd_nxt[LP_ORDER_MSB:LP_ORDER_LSB] = CFG.lp_order_sel;
                rd_nxt[LP_CORNER_MSB:LP_CORNER_LSB] = CFG.lp_corner_sel;
            end
            ADDR_CALIB_AND_DECIMATION_CFG:
            begin
                rd_nxt = CD_RSVD_IMAGE;
                rd_nxt[ZERO_CAL_BIT] = CFG.zero_cal_allow;
                rd_nxt[DECIM_MSB:DECIM_LSB] = CFG.output_decimation_sel;
            end
            ADDR_POWER_AND_READY_STATUS:
            begin
                // ready flag masked when not active
                rd_nxt[TEMP_READY_BIT] = TEMP_READY && active;
                rd_nxt[2:0] = pwr_r;
            end
            ADDR_TEMP_READ_ACCESS:
                rd_nxt = active ? TEMP_DATA : 8'h00;
            ADDR_RATE_READ_ACCESS:
                rd_nxt = active ? RATE_DATA : 8'h00;
            default:
                rd_nxt = 8'h00;
        endcase
    end

    // Read answer one cycle after the access
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            RD_VALID <= 1'b0;
            RD_DATA  <= 8'h00;
        end
        else
        begin
            RD_VALID <= rd;
            RD_DATA  <= rd ? rd_nxt : 8'h00;
        end
    end

endmodule : gdsp_regs

// [gdsp_regs_monitor.sv]
// Checker for the gyro DSP register bank, bound to its top module
`timescale 1ns/10ps
module gdsp_regs_monitor
(
    // Clock and reset
    input wire logic                   CLK,
    input wire logic                   RST,
    // Host access and answer
    input wire gdsp_pkg::gdsp_access_t ACC,
    input wire logic                   RD_VALID,
    input wire logic [7:0]             RD_DATA,
    // Controls
    input wire gdsp_pkg::gdsp_cfg_t    CFG,
    input wire logic                   DETECT_EN,
    input wire logic                   DATA_PATH_EN,
    input wire logic                   DSP_RESET,
    input wire logic                   ZERO_CAL_START,
    input wire logic                   TEMP_READ_STB,
    input wire logic                   RATE_READ_STB
);
    import gdsp_pkg::*;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    a_temp_read_strobe: assert property (ACC.valid && !ACC.write && ACC.addr == 8'h08
        |=> TEMP_READ_STB && RD_VALID) else $error("temperature read not answered");
    a_rate_read_strobe: assert property (ACC.valid && !ACC.write && ACC.addr == 8'h0a
        |=> RATE_READ_STB && RD_VALID) else $error("rate read not answered");
    a_status_code_legal: assert property (ACC.valid && !ACC.write && ACC.addr == 8'h04
        |=> RD_DATA[2:0] inside {3'b000, 3'b001, 3'b010, 3'b100} && RD_DATA[7:4] == 4'h0)
        else $error("illegal status code");
    a_idle_ready_masked: assert property (ACC.valid && !ACC.write && ACC.addr == 8'h04
        && !DATA_PATH_EN |=> !RD_DATA[3]) else $error("ready flag shown while idle");
    a_sleep_entry: assert property (ACC.valid && ACC.addr == 8'h05 |=> !DATA_PATH_EN)
        else $error("sleep command not taken");
    a_standby_entry: assert property (ACC.valid && ACC.addr == 8'h07 && DATA_PATH_EN
        |=> !DETECT_EN) else $error("standby did not stop detection");
    a_no_standby_asleep: assert property (ACC.valid && ACC.addr == 8'h07
        && !DATA_PATH_EN && DETECT_EN |=> DETECT_EN) else $error("standby entered from sleep");
    a_wake_pulse_shape: assert property ($rose(DSP_RESET)
        |-> DATA_PATH_EN && DETECT_EN ##1 !DSP_RESET) else $error("bad wake pulse");
    a_wake_only_cause: assert property (DSP_RESET
        |-> $past(ACC.valid && ACC.addr == 8'h06)) else $error("wake without command");
    a_cal_gated: assert property (ZERO_CAL_START
        |-> $past(ACC.valid && ACC.addr == 8'h0c && CFG.zero_cal_allow))
        else $error("calibration start not allowed");
    a_codes_legal: assert property (CFG.hp_corner_sel != 3'h7
        && CFG.lp_order_sel != 2'h3 && CFG.lp_corner_sel <= 4'hc)
        else $error("unavailable code stored");
endmodule : gdsp_regs_monitor

bind gdsp_regs gdsp_regs_monitor u_mon (.CLK(CLK), .RST(RST), .ACC(ACC), .RD_VALID(RD_VALID),
    .RD_DATA(RD_DATA), .CFG(CFG), .DETECT_EN(DETECT_EN), .DATA_PATH_EN(DATA_PATH_EN),
    .DSP_RESET(DSP_RESET), .ZERO_CAL_START(ZERO_CAL_START), .TEMP_READ_STB(TEMP_READ_STB),
    .RATE_READ_STB(RATE_READ_STB));

// [gdsp_host.sv]
// Host controller model issuing accesses to the register bank
`timescale 1ns/10ps
module gdsp_host
(
    // Clock
    input  wire logic             clk,
    // Access towards the bank
    output gdsp_pkg::gdsp_access_t acc,
    input  wire logic             rd_valid,
    input  wire logic [7:0]       rd_data
);
    import gdsp_pkg::*;
    initial acc = '0;

    // Released lines show the inverse so stale values never pass for live ones
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
        @(posedge clk);
        acc <= '{valid: 1'b1, write: wr, addr: addr, wdata: wdata};
        @(posedge clk);
        acc <= '{valid: 1'b0, write: ~wr, addr: ~addr, wdata: ~wdata};
        #1;
    endtask : access

    task automatic wr(input logic [7:0] addr, input logic [7:0] wdata);
        access(1'b1, addr, wdata);
    endtask : wr

    task automatic cmd(input logic [7:0] addr);
        access(1'b0, addr, 8'h00);
    endtask : cmd

    task automatic rd(input logic [7:0] addr, output logic [7:0] d, output logic v);
        access(1'b0, addr, 8'h00);
        v = rd_valid;
        d = rd_data;
    endtask : rd

    task automatic pause(input int n);
        repeat (n) @(posedge clk);
    endtask : pause
endmodule : gdsp_host

// [test_gdsp_regs.sv]
// Self-checking testbench for the gyro DSP register bank
`timescale 1ns/10ps
module test_gdsp_regs;
    import gdsp_pkg::*;
    logic         clk;
    logic         rst;
    logic         temp_ready;
    logic [7:0]   temp_data;
    logic [7:0]   rate_data;
    gdsp_access_t acc;
    logic         rd_valid;
    logic [7:0]   rd_data;
    gdsp_cfg_t    cfg;
    logic         detect_en;
    logic         data_path_en;
    logic         dsp_reset;
    logic         zero_cal_start;
    logic         temp_read_stb;
    logic         rate_read_stb;
    int           errors;
    int           comparisons;

    gdsp_regs u_dut (.CLK(clk), .RST(rst), .ACC(acc), .RD_VALID(rd_valid), .RD_DATA(rd_data),
        .TEMP_READY(temp_ready), .TEMP_DATA(temp_data), .RATE_DATA(rate_data), .CFG(cfg),
        .DETECT_EN(detect_en), .DATA_PATH_EN(data_path_en), .DSP_RESET(dsp_reset),
        .ZERO_CAL_START(zero_cal_start), .TEMP_READ_STB(temp_read_stb),
        .RATE_READ_STB(rate_read_stb));
    gdsp_host u_host (.clk(clk), .acc(acc), .rd_valid(rd_valid), .rd_data(rd_data));

    always #20 clk = ~clk;

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic rchk(input string what, input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        u_host.rd(addr, d, v);
        chk({what, " valid"}, {7'h0, v}, 8'h01);
        chk(what, d, exp);
    endtask : rchk

    task automatic results;
        if (errors == 0 && comparisons > 0)
        begin
            $display("TEST PASSED");
        end
        else
        begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    task automatic t_defaults;
        rchk("hp cfg", 8'h01, 8'h21);
        rchk("lp cfg", 8'h02, 8'h06);
        rchk("cd cfg", 8'h03, 8'h00);
        rchk("status", 8'h04, 8'h0c);
        @(posedge clk) temp_ready <= 1'b0;
        rchk("status", 8'h04, 8'h04);
        chk("hp on", {7'h0, cfg.hp_on}, 8'h00);
    endtask : t_defaults

    task automatic t_filters;
        u_host.wr(8'h01, 8'h73);
        rchk("hp cfg", 8'h01, 8'h23);
        chk("hp on", {7'h0, cfg.hp_on}, 8'h01);
        u_host.wr(8'h01, 8'h51);
        rchk("hp cfg", 8'h01, 8'h51);
        u_host.wr(8'h02, 8'h3e);
        rchk("lp cfg", 8'h02, 8'h06);
        u_host.wr(8'h02, 8'h2c);
        rchk("lp cfg", 8'h02, 8'h2c);
        for (int i = 0; i < 8; i++)
        begin
            u_host.wr(8'h03, 8'(i));
            chk("decim", {5'h0, cfg.output_decimation_sel}, 8'(i));
        end
        u_host.cmd(8'h09);
        rchk("hp cfg", 8'h01, 8'h21);
        rchk("lp cfg", 8'h02, 8'h06);
        rchk("cd cfg", 8'h03, 8'h00);
    endtask : t_filters

    task automatic t_cal;
        u_host.cmd(8'h0c);
        chk("cal start", {7'h0, zero_cal_start}, 8'h00);
        u_host.wr(8'h03, 8'h40);
        u_host.cmd(8'h0c);
        chk("cal start", {7'h0, zero_cal_start}, 8'h01);
        u_host.cmd(8'h09);
    endtask : t_cal

    task automatic t_power;
        @(posedge clk) temp_ready <= 1'b1;
        u_host.cmd(8'h05);
        chk("path en", {7'h0, data_path_en}, 8'h00);
        rchk("status", 8'h04, 8'h00);
        rchk("temp", 8'h08, 8'h00);
        chk("temp stb", {7'h0, temp_read_stb}, 8'h01);
        u_host.wr(8'h01, 8'h11);
        rchk("hp cfg", 8'h01, 8'h11);
        u_host.cmd(8'h07);
        rchk("status", 8'h04, 8'h00);
        u_host.pause(260);
        u_host.cmd(8'h06);
        chk("dsp reset", {7'h0, dsp_reset}, 8'h01);
        rchk("status", 8'h04, 8'h09);
        u_host.cmd(8'h07);
        chk("detect en", {7'h0, detect_en}, 8'h00);
        rchk("status", 8'h04, 8'h02);
        rchk("rate", 8'h0a, 8'h00);
        // Wake one cycle short of the wait must be dropped
        u_host.cmd(8'h07);
        u_host.pause(247);
        u_host.cmd(8'h06);
        chk("dsp reset", {7'h0, dsp_reset}, 8'h00);
        rchk("status", 8'h04, 8'h02);
        // Wake at exactly the wait is honoured
        u_host.cmd(8'h07);
        u_host.pause(248);
        u_host.cmd(8'h06);
        chk("dsp reset", {7'h0, dsp_reset}, 8'h01);
        rchk("status", 8'h04, 8'h09);
        rchk("rate", 8'h0a, 8'h5a);
        chk("rate stb", {7'h0, rate_read_stb}, 8'h01);
        @(posedge clk) {temp_data, rate_data} <= 16'hc33c;
        rchk("rate", 8'h0a, 8'h3c);
        u_host.wr(8'h08, 8'h33);
        rchk("temp", 8'h08, 8'hc3);
        u_host.wr(8'h04, 8'hff);
        rchk("status", 8'h04, 8'h09);
    endtask : t_power

    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        temp_ready = 1'b1;
        temp_data = 8'ha5;
        rate_data = 8'h5a;
        errors = 0;
        comparisons = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_defaults();
        t_filters();
        t_cal();
        t_power();
        results();
    end

    // Whole run needs under 1500 cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        results();
    end
endmodule : test_gdsp_regs
